// *** hw/cpmc_map.svh ***
// Register map, field positions, reset values and timing counts of the
// power mode sequencer. Assumes a 50 MHz system clock.
`ifndef CPMC_MAP_SVH
`define CPMC_MAP_SVH

`define CPMC_CLK_MHZ        50
`define CPMC_SEC_CYCLES     (`CPMC_CLK_MHZ * 1000000)
`define CPMC_INACT_S        8'd6
`define CPMC_TOGGLE_MIN_US  1000
`define CPMC_TOGGLE_MIN_CYC (`CPMC_TOGGLE_MIN_US * `CPMC_CLK_MHZ)
`define CPMC_BOOT_CYC       1000
`define CPMC_SHUT_CYC       1000

`define CPMC_OFS_CTRL       8'h00
`define CPMC_OFS_DRX        8'h04
`define CPMC_OFS_PERIODIC   8'h08
`define CPMC_OFS_CMD        8'h0c
`define CPMC_OFS_STATUS     8'h10

`define CPMC_CMD_OFF_BIT    0
`define CPMC_ST_IFACE_BIT   4
`define CPMC_ST_MODON_BIT   5
`define CPMC_ST_SUPOK_BIT   6
`define CPMC_CTRL_RST       6'h00
`define CPMC_TIMER_RST      16'h0000

`define CPMC_RESP_OKAY      2'h0
`define CPMC_RESP_SLVERR    2'h2

`endif

// *** hw/cpmc_pkg.sv ***
// Types shared by the power mode sequencer, its assertions and its testbench.
// Assumes the map header supplies all numeric constants.
package cpmc_pkg;

  typedef enum logic [3:0] {
    ST_UNPOWERED,
    ST_OFF,
    ST_BOOT,
    ST_ACTIVE,
    ST_CONNECTED,
    ST_IDLE,
    ST_SAVING,
    ST_DEEP,
    ST_SHUTDOWN
  } cpmc_state_t;

  typedef struct packed {
    logic       edrxSleep;
    logic       operatorAllow;
    logic       savingAlt;
    logic       savingEnable;
    logic [1:0] idleMode;
  } cpmc_cfg_t;

endpackage : cpmc_pkg

// *** hw/cpmc_reg_if.sv ***
// Register access bundle between the bus slave and the sequencer core.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cpmc_reg_if #(parameter int ADDR_W = 8);
  logic              wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0]       wrData;
  logic [3:0]        wrStrb;
  logic              wrErr;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0]       rdData;
  logic              rdErr;

  modport bus  (output wrEn, wrAddr, wrData, wrStrb, rdAddr, input wrErr, rdData, rdErr);
  modport regs (input wrEn, wrAddr, wrData, wrStrb, rdAddr, output wrErr, rdData, rdErr);
endinterface : cpmc_reg_if

// *** hw/cpmc_axil_slave.sv ***
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes one write and one read under way at a time.
`timescale 1ns/100ps
`include "cpmc_map.svh"
module cpmc_axil_slave #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output      logic              s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output      logic              s_axil_wready,
  output      logic [1:0]        s_axil_bresp,
  output      logic              s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output      logic              s_axil_arready,
  output      logic [31:0]       s_axil_rdata,
  output      logic [1:0]        s_axil_rresp,
  output      logic              s_axil_rvalid,
  input  wire logic              s_axil_rready,
  cpmc_reg_if.bus                rif
);
  logic              awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [31:0]       wData_r, wData_nxt, rData_r, rData_nxt;
  logic [3:0]        wStrb_r, wStrb_nxt;
  logic              bValid_r, bValid_nxt, rValid_r, rValid_nxt;
  logic [1:0]        bResp_r, bResp_nxt, rResp_r, rResp_nxt;

  assign s_axil_awready = !awHeld_r && !bValid_r;
  assign s_axil_wready  = !wHeld_r && !bValid_r;
  assign s_axil_arready = !rValid_r;
  assign s_axil_bvalid  = bValid_r;
  assign s_axil_bresp   = bResp_r;
  assign s_axil_rvalid  = rValid_r;
  assign s_axil_rdata   = rData_r;
  assign s_axil_rresp   = rResp_r;
  assign rif.wrEn       = awHeld_r && wHeld_r && !bValid_r;
  assign rif.wrAddr     = awAddr_r;
  assign rif.wrData     = wData_r;
  assign rif.wrStrb     = wStrb_r;
  assign rif.rdAddr     = s_axil_araddr;

  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt  = wHeld_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    if (s_axil_awvalid && s_axil_awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axil_wdata;
      wStrb_nxt = s_axil_wstrb;
    end
    if (rif.wrEn) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = rif.wrErr ? `CPMC_RESP_SLVERR : `CPMC_RESP_OKAY;
    end else if (bValid_r && s_axil_bready) begin
      bValid_nxt = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready) begin
      rValid_nxt = 1'b1;
      rData_nxt  = rif.rdData;
      rResp_nxt  = rif.rdErr ? `CPMC_RESP_SLVERR : `CPMC_RESP_OKAY;
    end else if (rValid_r && s_axil_rready) begin
      rValid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r  <= `CPMC_RESP_OKAY;
      rValid_r <= 1'b0;
      rData_r  <= 32'h0;
      rResp_r  <= `CPMC_RESP_OKAY;
    end else begin
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r  <= wHeld_nxt;
      wData_r  <= wData_nxt;
      wStrb_r  <= wStrb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r  <= bResp_nxt;
      rValid_r <= rValid_nxt;
      rData_r  <= rData_nxt;
      rResp_r  <= rResp_nxt;
    end
  end
endmodule : cpmc_axil_slave

// *** hw/cpmc_power_mode_control.sv ***
// Operating mode sequencer of a cellular modem with an AXI4-Lite register port.
// Assumes supply comparators, toggle pin and activity flags are synchronous to clk.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "cpmc_map.svh"
module cpmc_power_mode_control #(
  parameter int ADDR_W         = 8,
  parameter int SEC_CYCLES     = `CPMC_SEC_CYCLES,
  parameter int TOGGLE_MIN_CYC = `CPMC_TOGGLE_MIN_CYC,
  parameter int BOOT_CYC       = `CPMC_BOOT_CYC,
  parameter int SHUT_CYC       = `CPMC_SHUT_CYC
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [ADDR_W-1:0]  s_axil_awaddr,
  input  wire logic               s_axil_awvalid,
  output      logic               s_axil_awready,
  input  wire logic [31:0]        s_axil_wdata,
  input  wire logic [3:0]         s_axil_wstrb,
  input  wire logic               s_axil_wvalid,
  output      logic               s_axil_wready,
  output      logic [1:0]         s_axil_bresp,
  output      logic               s_axil_bvalid,
  input  wire logic               s_axil_bready,
  input  wire logic [ADDR_W-1:0]  s_axil_araddr,
  input  wire logic               s_axil_arvalid,
  output      logic               s_axil_arready,
  output      logic [31:0]        s_axil_rdata,
  output      logic [1:0]         s_axil_rresp,
  output      logic               s_axil_rvalid,
  input  wire logic               s_axil_rready,
  input  wire logic               supplyPresent,
  input  wire logic               supplyAboveMin,
  input  wire logic               powerToggleN,
  input  wire logic               rfActivity,
  input  wire logic               concurrentActivity,
  input  wire logic               hostTraffic,
  output      cpmc_pkg::cpmc_state_t opState,
  output      logic               interfacesOn,
  output      logic               moduleOn
);
  import cpmc_pkg::*;

  if (ADDR_W < 5 || SEC_CYCLES < 1 || SEC_CYCLES >= 2**26 || TOGGLE_MIN_CYC < 1 ||
      TOGGLE_MIN_CYC >= 2**24 || BOOT_CYC < 1 || BOOT_CYC >= 2**16 ||
      SHUT_CYC < 1 || SHUT_CYC >= 2**16) begin : gBadParam
    $error("cpmc_power_mode_control: parameter out of range");
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  cpmc_reg_if #(.ADDR_W(ADDR_W)) rif ();

  cpmc_axil_slave #(.ADDR_W(ADDR_W)) uSlave (
    .clk            (clk),
    .srst           (srst),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .rif            (rif)
  );

  // Word match against a register offset; the two low address bits are ignored.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    hit = ({addr[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs));
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = hit(addr, `CPMC_OFS_CTRL) || hit(addr, `CPMC_OFS_DRX) ||
             hit(addr, `CPMC_OFS_PERIODIC) || hit(addr, `CPMC_OFS_CMD) ||
             hit(addr, `CPMC_OFS_STATUS);
  endfunction : mapped

  // Byte-lane merge of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  cpmc_cfg_t   cfg_r, cfg_nxt;
  logic [15:0] drxSec_r, drxSec_nxt, periodicSec_r, periodicSec_nxt;
  cpmc_state_t state_r, state_nxt;
  logic        hostOk;
  logic        cmdWr;
  logic        offCmd;
  logic        activity;

  assign hostOk   = (state_r == ST_ACTIVE) || (state_r == ST_CONNECTED) ||
                    (state_r == ST_IDLE);
  assign cmdWr    = rif.wrEn && hostOk && mapped(rif.wrAddr);
  assign offCmd   = cmdWr && hit(rif.wrAddr, `CPMC_OFS_CMD) && rif.wrStrb[0] &&
                    rif.wrData[`CPMC_CMD_OFF_BIT];
  assign activity = cmdWr || (hostTraffic && hostOk);

  assign rif.wrErr = !mapped(rif.wrAddr);
  assign rif.rdErr = !mapped(rif.rdAddr);

  always_comb begin
    rif.rdData = 32'h0;
    if (hit(rif.rdAddr, `CPMC_OFS_CTRL)) begin
      rif.rdData[$bits(cpmc_cfg_t)-1:0] = cfg_r;
    end else if (hit(rif.rdAddr, `CPMC_OFS_DRX)) begin
      rif.rdData[15:0] = drxSec_r;
    end else if (hit(rif.rdAddr, `CPMC_OFS_PERIODIC)) begin
      rif.rdData[15:0] = periodicSec_r;
    end else if (hit(rif.rdAddr, `CPMC_OFS_STATUS)) begin
      rif.rdData[3:0]                = state_r;
      rif.rdData[`CPMC_ST_IFACE_BIT] = interfacesOn;
      rif.rdData[`CPMC_ST_MODON_BIT] = moduleOn;
      rif.rdData[`CPMC_ST_SUPOK_BIT] = supplyAboveMin;
    end
  end

  always_comb begin
    cfg_nxt         = cfg_r;
    drxSec_nxt      = drxSec_r;
    periodicSec_nxt = periodicSec_r;
    if (cmdWr && rif.wrStrb[0] && hit(rif.wrAddr, `CPMC_OFS_CTRL)) begin
      cfg_nxt = cpmc_cfg_t'(rif.wrData[$bits(cpmc_cfg_t)-1:0]);
    end
    if (cmdWr && hit(rif.wrAddr, `CPMC_OFS_DRX)) begin
      drxSec_nxt = merge16(drxSec_r, rif.wrData, rif.wrStrb);
    end
    if (cmdWr && hit(rif.wrAddr, `CPMC_OFS_PERIODIC)) begin
      periodicSec_nxt = merge16(periodicSec_r, rif.wrData, rif.wrStrb);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r         <= cpmc_cfg_t'(`CPMC_CTRL_RST);
      drxSec_r      <= `CPMC_TIMER_RST;
      periodicSec_r <= `CPMC_TIMER_RST;
    end else begin
      cfg_r         <= cfg_nxt;
      drxSec_r      <= drxSec_nxt;
      periodicSec_r <= periodicSec_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Second tick and toggle detection
  // ----------------------------------------------------------------
  logic [25:0] tickCnt_r, tickCnt_nxt;
  logic [23:0] pressCnt_r, pressCnt_nxt;
  logic        secTick;
  logic        toggleEvt;

  assign secTick = (tickCnt_r == 26'(SEC_CYCLES - 1));
  // Held low long enough, then released.
  assign toggleEvt = powerToggleN && (pressCnt_r >= 24'(TOGGLE_MIN_CYC));

  always_comb begin
    tickCnt_nxt  = secTick ? 26'h0 : tickCnt_r + 26'h1;
    pressCnt_nxt = pressCnt_r;
    if (powerToggleN) begin
      pressCnt_nxt = 24'h0;
    end else if (pressCnt_r != 24'hffffff) begin
      pressCnt_nxt = pressCnt_r + 24'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tickCnt_r  <= 26'h0;
      pressCnt_r <= 24'h0;
    end else begin
      tickCnt_r  <= tickCnt_nxt;
      pressCnt_r <= pressCnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode sequencer
  // ----------------------------------------------------------------
  logic [15:0] phase_r, phase_nxt, sleep_r, sleep_nxt;
  logic [7:0]  inact_r, inact_nxt;
  logic        iface_r, iface_nxt, modOn_r, modOn_nxt;
  logic        sleepDone, inactDone, savingOk, running;

  assign sleepDone = (sleep_r == 16'h0);
  assign inactDone = (inact_r == `CPMC_INACT_S);
  assign savingOk  = (cfg_r.savingEnable || cfg_r.savingAlt) && cfg_r.operatorAllow;
  assign running   = (state_r != ST_UNPOWERED) && (state_r != ST_OFF) &&
                     (state_r != ST_SHUTDOWN);

  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    sleep_nxt = sleep_r;
    inact_nxt = inact_r;
    if (activity) begin
      inact_nxt = 8'h0;
    end else if (secTick && !inactDone) begin
      inact_nxt = inact_r + 8'h1;
    end
    if (secTick && !sleepDone) begin
      sleep_nxt = sleep_r - 16'h1;
    end
    // Undefined requests leave the state alone.
    unique case (state_r)
      ST_UNPOWERED: begin
        if (supplyPresent) state_nxt = ST_OFF;
      end
      ST_OFF: begin
        if (toggleEvt && supplyAboveMin) begin
          state_nxt = ST_BOOT;
          phase_nxt = 16'h0;
        end
      end
      ST_BOOT: begin
        phase_nxt = phase_r + 16'h1;
        if (phase_r == 16'(BOOT_CYC - 1)) begin
          state_nxt = ST_ACTIVE;
          inact_nxt = 8'h0;
        end
      end
      ST_ACTIVE: begin
        if (offCmd || toggleEvt) begin
          state_nxt = ST_SHUTDOWN;
          phase_nxt = 16'h0;
        end else if (rfActivity) begin
          state_nxt = ST_CONNECTED;
        end else if (inactDone && !activity && !concurrentActivity) begin
          if (savingOk) begin
            state_nxt = ST_SAVING;
            sleep_nxt = periodicSec_r;
          end else if (cfg_r.edrxSleep) begin
            state_nxt = ST_DEEP;
            sleep_nxt = drxSec_r;
          end else if (cfg_r.idleMode != 2'h0) begin
            state_nxt = ST_IDLE;
            sleep_nxt = drxSec_r;
          end
        end
      end
      ST_CONNECTED: begin
        if (offCmd || toggleEvt) begin
          state_nxt = ST_SHUTDOWN;
          phase_nxt = 16'h0;
        end else if (!rfActivity) begin
          state_nxt = ST_ACTIVE;
          inact_nxt = 8'h0;
        end
      end
      ST_IDLE: begin
        if (offCmd || toggleEvt) begin
          state_nxt = ST_SHUTDOWN;
          phase_nxt = 16'h0;
        // DRX, concurrency and setting end idle.
        end else if (rfActivity || concurrentActivity || sleepDone ||
                     (activity && cfg_r.idleMode[1])) begin
          state_nxt = ST_ACTIVE;
          inact_nxt = 8'h0;
        end
      end
      ST_SAVING: begin
        if (toggleEvt || sleepDone) begin
          state_nxt = ST_ACTIVE;
          inact_nxt = 8'h0;
        end else if (!concurrentActivity) begin
          state_nxt = ST_DEEP;
        end
      end
      ST_DEEP: begin
        if (toggleEvt || sleepDone) begin
          state_nxt = ST_ACTIVE;
          inact_nxt = 8'h0;
        end
      end
      ST_SHUTDOWN: begin
        phase_nxt = phase_r + 16'h1;
        if (phase_r == 16'(SHUT_CYC - 1)) state_nxt = ST_OFF;
      end
    endcase
    if (running && !supplyAboveMin) begin
      state_nxt = ST_SHUTDOWN;
      phase_nxt = 16'h0;
    end
    if (!supplyPresent) state_nxt = ST_UNPOWERED;
    iface_nxt = (state_nxt == ST_ACTIVE) || (state_nxt == ST_CONNECTED) ||
                (state_nxt == ST_IDLE);
    modOn_nxt = (state_nxt != ST_UNPOWERED) && (state_nxt != ST_OFF);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_UNPOWERED;
      phase_r <= 16'h0;
      sleep_r <= 16'h0;
      inact_r <= 8'h0;
      iface_r <= 1'b0;
      modOn_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      sleep_r <= sleep_nxt;
      inact_r <= inact_nxt;
      iface_r <= iface_nxt;
      modOn_r <= modOn_nxt;
    end
  end

  assign opState      = state_r;
  assign interfacesOn = iface_r;
  assign moduleOn     = modOn_r;
endmodule : cpmc_power_mode_control

// *** dv/cpmc_host_model.sv ***
// Host-side model that presses the power toggle pin for a set time.
// Assumes go is a one-cycle request synchronous to clk; the pin idles high.
`timescale 1ns/100ps
module cpmc_host_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] lowCycles,
  output      logic       powerToggleN
);
  logic [7:0] cnt_r = 8'h00;
  logic [7:0] cnt_nxt;
  always_comb cnt_nxt = go ? lowCycles : cnt_r - 8'(cnt_r != 8'h00);
  always_ff @(posedge clk) cnt_r <= cnt_nxt;
  assign powerToggleN = (cnt_r == 8'h00);
endmodule : cpmc_host_model

// *** dv/cpmc_power_mode_control_assertions.sv ***
// Concurrent checks on the mode sequencer's top ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module cpmc_power_mode_control_assertions (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  supplyPresent,
  input wire logic                  supplyAboveMin,
  input wire logic                  powerToggleN,
  input wire logic                  rfActivity,
  input wire logic                  concurrentActivity,
  input wire cpmc_pkg::cpmc_state_t opState,
  input wire logic                  interfacesOn,
  input wire logic                  moduleOn
);
  import cpmc_pkg::*;
  localparam logic [10:0] SHUT_MAX = 11'd1000;
  logic [10:0] shutCnt_r, shutCnt_nxt;
  // Counts the cycles spent in the current switch-off routine.
  always_comb shutCnt_nxt = (opState == ST_SHUTDOWN) ? shutCnt_r + 11'h1 : 11'h0;
  always_ff @(posedge clk) shutCnt_r <= srst ? 11'h0 : shutCnt_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  no_supply_a: assert property (
    !supplyPresent |=> opState == ST_UNPOWERED) else $error("not unpowered");
  module_on_a: assert property (
    moduleOn == !(opState inside {ST_UNPOWERED, ST_OFF})) else $error("moduleOn wrong");
  off_hold_a: assert property (
    opState == ST_OFF && powerToggleN && $past(powerToggleN) |=> opState != ST_BOOT)
    else $error("self start");
  boot_gate_a: assert property (
    opState == ST_OFF && !supplyAboveMin |=> opState != ST_BOOT) else $error("low boot");
  iface_map_a: assert property (
    interfacesOn == (opState inside {ST_ACTIVE, ST_CONNECTED, ST_IDLE}))
    else $error("interfacesOn wrong");
  rf_connect_a: assert property (
    opState == ST_ACTIVE && rfActivity |=> opState inside {ST_CONNECTED, ST_SHUTDOWN,
    ST_UNPOWERED}) else $error("no connect");
  conn_end_a: assert property (
    opState == ST_CONNECTED && !rfActivity |=> opState inside {ST_ACTIVE, ST_SHUTDOWN,
    ST_UNPOWERED}) else $error("stuck connected");
  deep_gate_a: assert property (
    opState == ST_SAVING && concurrentActivity && powerToggleN |=> opState != ST_DEEP)
    else $error("deep with activity");
  brown_out_a: assert property (
    supplyPresent && !supplyAboveMin && opState inside {ST_BOOT, ST_ACTIVE, ST_CONNECTED,
    ST_IDLE, ST_SAVING, ST_DEEP} |=> opState == ST_SHUTDOWN) else $error("no brown-out");
  shut_end_a: assert property (
    opState == ST_SHUTDOWN |-> shutCnt_r < SHUT_MAX) else $error("shutdown endless");
endmodule : cpmc_power_mode_control_assertions
bind cpmc_power_mode_control cpmc_power_mode_control_assertions
  cpmc_power_mode_control_assertions_inst (.clk(clk), .srst(srst),
  .supplyPresent(supplyPresent), .supplyAboveMin(supplyAboveMin),
  .powerToggleN(powerToggleN), .rfActivity(rfActivity),
  .concurrentActivity(concurrentActivity), .opState(opState),
  .interfacesOn(interfacesOn), .moduleOn(moduleOn));

// *** dv/tb_cellular_power_mode_control.sv ***
// Self-checking bench of the mode sequencer through its pins and AXI4-Lite port.
// Assumes shortened second, toggle, boot and shutdown counts.
`timescale 1ns/100ps
module tb_cellular_power_mode_control;
  import cpmc_pkg::*;
  localparam int SEC = 20;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lowCyc = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, drx, seed = 32'hb3b4;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, pinN, ifOn, modOn;
  logic [1:0]  bresp, rresp;
  logic        supOk = 0, supMin = 0, rfAct = 0, concAct = 0, hostTr = 0, go = 0;
  cpmc_state_t st;
  int          bad_count = 0, comparisons = 0;

  initial forever #10 clk = ~clk;

  cpmc_power_mode_control #(.SEC_CYCLES(SEC), .TOGGLE_MIN_CYC(4), .BOOT_CYC(4),
    .SHUT_CYC(4)) cpmc_power_mode_control_inst (.clk(clk), .srst(srst),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .supplyPresent(supOk),
    .supplyAboveMin(supMin), .powerToggleN(pinN), .rfActivity(rfAct),
    .concurrentActivity(concAct), .hostTraffic(hostTr), .opState(st),
    .interfacesOn(ifOn), .moduleOn(modOn));
  cpmc_host_model cpmc_host_model_inst (.clk(clk), .go(go), .lowCycles(lowCyc),
    .powerToggleN(pinN));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Status word the sequencer should report in a settled state.
  function automatic logic [31:0] expStatus(input cpmc_state_t s);
    return {25'h0, supMin, !(s inside {ST_UNPOWERED, ST_OFF}),
            s inside {ST_ACTIVE, ST_CONNECTED, ST_IDLE}, s};
  endfunction : expStatus

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic waitSt(input cpmc_state_t s, input int lim);
    for (int n = 0; n < lim && st !== s; n++) @(negedge clk);
    chk(32'(st), 32'(s));
    if (st !== s) print_verdict();
  endtask : waitSt

  task automatic press(input int n);
    @(posedge clk);
    go <= 1'b1;
    lowCyc <= 8'(n);
    @(posedge clk);
    go <= 1'b0;
    repeat (n + 2) @(posedge clk);
    @(negedge clk);
  endtask : press

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    logic tb = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid & bready;
      if (tb) chk(32'(bresp), 32'(er));
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) begin chk(0, 1); print_verdict(); end
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta;
    logic tr = 1'b0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge clk);
      ta = arvalid & arready; tr = rvalid & rready;
      if (tr) begin chk(rdata, ed); chk(32'(rresp), 32'(er)); end
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) begin chk(0, 1); print_verdict(); end
  endtask : axiRd

  task automatic powerOn();
    press(4 + int'(xs() % 32'd4));
    waitSt(ST_ACTIVE, 20);
  endtask : powerOn

  initial begin
    repeat (20000) @(posedge clk);
    chk(0, 1);
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(32'(st), 32'(ST_UNPOWERED));
    axiRd(8'h10, 32'h0, 2'h0);
    @(posedge clk) supOk <= 1'b1;
    waitSt(ST_OFF, 5);
    press(6);
    chk(32'(st), 32'(ST_OFF));
    @(posedge clk) supMin <= 1'b1;
    press(2);
    chk(32'(st), 32'(ST_OFF));
    powerOn();
    axiRd(8'h10, expStatus(ST_ACTIVE), 2'h0);
    axiRd(8'h1c, 32'h0, 2'h2);
    axiWr(8'h1c, 32'h1, 2'h2);
    @(posedge clk) rfAct <= 1'b1;
    waitSt(ST_CONNECTED, 5);
    @(posedge clk) rfAct <= 1'b0;
    waitSt(ST_ACTIVE, 5);
    drx = xs() % 32'd3 + 32'd1;
    axiWr(8'h04, drx, 2'h0);
    axiRd(8'h04, drx, 2'h0);
    axiWr(8'h00, 32'h1, 2'h0);
    repeat (95) @(negedge clk);
    chk(32'(st), 32'(ST_ACTIVE));
    waitSt(ST_IDLE, 100);
    waitSt(ST_ACTIVE, int'(drx) * SEC + SEC);
    waitSt(ST_IDLE, 200);
    @(posedge clk) concAct <= 1'b1;
    waitSt(ST_ACTIVE, 5);
    axiWr(8'h08, 32'h6, 2'h0);
    axiWr(8'h00, 32'h14, 2'h0);
    @(posedge clk) concAct <= 1'b0;
    waitSt(ST_SAVING, 200);
    waitSt(ST_DEEP, 5);
    @(posedge clk) hostTr <= 1'b1;
    axiWr(8'h00, 32'h0, 2'h0);
    @(posedge clk) hostTr <= 1'b0;
    axiRd(8'h10, expStatus(ST_DEEP), 2'h0);
    waitSt(ST_ACTIVE, 150);
    axiRd(8'h00, 32'h14, 2'h0);
    axiWr(8'h00, 32'h18, 2'h0);
    // Alternating activity holds power saving one cycle before deep sleep.
    for (int n = 0; n < 300 && st !== ST_DEEP; n++) begin
      @(posedge clk) concAct <= !concAct;
      @(negedge clk);
    end
    @(posedge clk) concAct <= 1'b0;
    waitSt(ST_DEEP, 1);
    press(5);
    waitSt(ST_ACTIVE, 5);
    axiWr(8'h00, 32'h2a, 2'h0);
    waitSt(ST_DEEP, 200);
    waitSt(ST_ACTIVE, int'(drx) * SEC + SEC);
    axiWr(8'h04, 32'h10, 2'h0);
    axiWr(8'h00, 32'h2, 2'h0);
    waitSt(ST_IDLE, 200);
    @(posedge clk) hostTr <= 1'b1;
    waitSt(ST_ACTIVE, 3);
    @(posedge clk) hostTr <= 1'b0;
    axiWr(8'h0c, 32'h1, 2'h0);
    waitSt(ST_SHUTDOWN, 5);
    waitSt(ST_OFF, 10);
    powerOn();
    press(6);
    waitSt(ST_OFF, 10);
    powerOn();
    @(posedge clk) supMin <= 1'b0;
    waitSt(ST_SHUTDOWN, 3);
    waitSt(ST_OFF, 10);
    @(posedge clk) supOk <= 1'b0;
    waitSt(ST_UNPOWERED, 3);
    print_verdict();
  end
endmodule : tb_cellular_power_mode_control
